//--- dv/fbss_ctrl_model.sv
`timescale 1ns/100ps
module fbss_ctrl_model (
  input wire logic i_clk,
  output logic [fbss_pkg::ADDR_W-1:0] o_addr,
  output logic [fbss_pkg::DATA_W-1:0] o_dq,
  output logic o_ps_n,
  output logic o_cs_n,
  output logic o_step_n,
  output logic o_gw_n,
  output logic o_gate_n,
  output logic [fbss_pkg::LANES-1:0] o_lane_n,
  output logic o_ce0_n,
  output logic o_ce1,
  output logic o_ce2_n,
  output logic o_oe_n,
  output logic o_order,
  output logic o_sleep
);
  initial begin
    {o_ps_n, o_cs_n, o_step_n, o_gw_n, o_gate_n, o_lane_n} = 7'h7f;
    {o_ce0_n, o_ce1, o_ce2_n, o_oe_n, o_order, o_sleep} = 6'h16;
    o_addr = 20'h0;
    o_dq = 18'h0;
  end

  task cyc(input logic ps, cs, st, gw, gt, input logic [1:0] ln, input logic [19:0] a,
           input logic [17:0] d);
    @(posedge i_clk);
    {o_ps_n, o_cs_n, o_step_n, o_gw_n, o_gate_n, o_lane_n} <= {ps, cs, st, gw, gt, ln};
    o_addr <= a;
    // bus released when not writing: keep it toggling so stale data never matches
    o_dq <= (gw & gt) ? ~o_dq : d;
  endtask : cyc

  task idle(input int n);
    repeat (n) cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, o_addr, o_dq);
  endtask : idle

  task pins(input logic oe, ord, slp, c0, c1, c2);
    @(posedge i_clk);
    {o_oe_n, o_order, o_sleep, o_ce0_n, o_ce1, o_ce2_n} <= {oe, ord, slp, c0, c1, c2};
  endtask : pins

  task wr_prep(input logic ord);
    pins(1'b1, ord, 1'b0, 1'b0, 1'b1, 1'b0);
    idle(4);
  endtask : wr_prep
endmodule : fbss_ctrl_model

//--- dv/tb.sv
`timescale 1ns/100ps
module tb;
  logic I_CLK = 1'b0;
  logic I_ARST_N = 1'b0;
  logic [fbss_pkg::ADDR_W-1:0] addr;
  logic [fbss_pkg::DATA_W-1:0] dq_in, O_DQ;
  logic [1:0] lane_n;
  logic O_DQ_OE, ps_n, cs_n, step_n, gw_n, gate_n, ce0_n, ce1, ce2_n, oe_n, ord_sel, slp;
  int err_count = 0;
  int checks = 0;
  logic [31:0] seed = 32'h8060fea1;
  logic [17:0] exp_mem [logic [19:0]];

  always #50 I_CLK = ~I_CLK;

  fbss_ctrl_model ctl (.i_clk(I_CLK), .o_addr(addr), .o_dq(dq_in), .o_ps_n(ps_n),
    .o_cs_n(cs_n), .o_step_n(step_n), .o_gw_n(gw_n), .o_gate_n(gate_n), .o_lane_n(lane_n),
    .o_ce0_n(ce0_n), .o_ce1(ce1), .o_ce2_n(ce2_n), .o_oe_n(oe_n), .o_order(ord_sel),
    .o_sleep(slp));

  fbss_top dut (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_ADDR(addr), .I_DQ(dq_in),
    .O_DQ(O_DQ), .O_DQ_OE(O_DQ_OE), .I_PROC_ADDR_STROBE_N(ps_n),
    .I_CTRL_ADDR_STROBE_N(cs_n), .I_BURST_STEP_N(step_n), .I_ALL_LANES_WRITE_N(gw_n),
    .I_LANE_WRITE_GATE_N(gate_n), .I_LANE_WRITE_N(lane_n), .I_MASTER_SELECT_N(ce0_n),
    .I_SELECT_HI(ce1), .I_SELECT_LO_N(ce2_n), .I_OUT_EN_N(oe_n),
    .I_BURST_ORDER_SEL(ord_sel), .I_SLEEP_REQ(slp));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [19:0] baddr(input logic [19:0] a, input int k, input logic o);
    baddr = a;
    baddr[1:0] = o ? (a[1:0] ^ k[1:0]) : (a[1:0] + k[1:0]);
  endfunction : baddr

  function automatic logic [17:0] merge(input logic [17:0] m, d, input logic [1:0] ln);
    if (!ln[0]) m[8:0] = d[8:0];
    if (!ln[1]) m[17:9] = d[17:9];
    return m;
  endfunction : merge

  task chk(input logic [17:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task test_done;
    $display("mismatches %0d comparisons %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  task rd_next(input logic [19:0] a, input logic en);
    ctl.idle(1);
    #1;
    chk({17'h0, O_DQ_OE}, {17'h0, en});
    chk(O_DQ, exp_mem[a]);
  endtask : rd_next

  initial begin : watchdog
    #(100 * 3000);
    err_count++;
    test_done();
  end

  initial begin : main
    logic [19:0] a;
    logic [17:0] d;
    logic [1:0] ln [4];
    logic o;
    logic oe;
    ln = '{2'h2, 2'h1, 2'h0, 2'h3};
    repeat (10) @(posedge I_CLK);
    I_ARST_N <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      o = r[0];
      oe = r[1];
      seed = lfsr(seed);
      a = seed[19:0];
      ctl.wr_prep(o);
      seed = lfsr(seed);
      ctl.cyc(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 2'h3, a, seed[17:0]);
      exp_mem[a] = seed[17:0];
      for (int k = 0; k < 4; k++) begin
        seed = lfsr(seed);
        d = seed[17:0];
        // last step writes all lanes with global write and holds the address
        ctl.cyc(1'b1, 1'b1, k == 3, k != 3, k == 3, ln[k], a, d);
        exp_mem[baddr(a, k, o)] = (k == 3) ? d : merge(exp_mem[baddr(a, k, o)], d, ln[k]);
      end
      ctl.pins(oe, o, 1'b0, 1'b0, 1'b1, 1'b0);
      ctl.idle(4);
      // lane, write, step and controller strobe ignored on the processor start
      ctl.cyc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, a, d);
      for (int k = 0; k < 4; k++) begin
        ctl.cyc(1'b1, 1'b1, k == 3, 1'b1, 1'b1, 2'h3, a, d);
        #1;
        chk(O_DQ, exp_mem[baddr(a, k, o)]);
      end
      rd_next(baddr(a, 3, o), !oe);
      seed = lfsr(seed);
      ctl.cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'h2, a, seed[17:0]);
      exp_mem[baddr(a, 3, o)] = merge(exp_mem[baddr(a, 3, o)], seed[17:0], 2'h2);
      ctl.idle(1);
      #1;
      chk({17'h0, O_DQ_OE}, 18'h0);
      rd_next(baddr(a, 3, o), !oe);
    end
    // master enable high blocks the processor strobe: no new address loaded
    ctl.pins(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    ctl.cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, a ^ 20'hffffc, d);
    ctl.idle(1);
    #1;
    chk(O_DQ, exp_mem[baddr(a, 3, o)]);
    for (int c = 0; c < 3; c++) begin
      // one enable inactive at a time: the controller strobe deselects
      ctl.pins(1'b0, 1'b1, 1'b0, c == 0, c != 1, c == 2);
      ctl.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'h3, a, d);
      ctl.idle(1);
      #1;
      chk({17'h0, O_DQ_OE}, 18'h0);
      ctl.pins(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      ctl.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'h3, a, d);
      rd_next(a, 1'b1);
    end
    // sleep: strobes ignored, outputs float, address and data kept
    ctl.pins(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    ctl.idle(4);
    ctl.cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, a ^ 20'hffffc, d);
    ctl.idle(1);
    #1;
    chk({17'h0, O_DQ_OE}, 18'h0);
    ctl.pins(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    ctl.idle(4);
    rd_next(a, 1'b1);
    test_done();
  end
endmodule : tb

//--- rtl/fbss_burst_seq.sv
`timescale 1ns/100ps
module fbss_burst_seq (
  input wire logic [1:0] i_base,
  input wire logic [1:0] i_count,
  input wire logic i_linear,
  output logic [1:0] o_offset
);
  // linear order adds the count, interleaved order flips bits of the start
  always_comb begin
    if (i_linear) begin
      o_offset = 2'(i_base + i_count);
    end else begin
      o_offset = i_base ^ i_count;
    end
  end
endmodule : fbss_burst_seq

//--- rtl/fbss_pkg.sv
package fbss_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int DEPTH = 1048576;
  localparam int BURST_W = 2;
  localparam int SYNC_STAGES = 3;
  // values held by the pin filters after reset, then burst counter and lane constants
  localparam logic OUT_EN_N_RST = 1'h1;
  localparam logic ORDER_SEL_RST = 1'h1;
  localparam logic SLEEP_RST = 1'h0;
  localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_CNT_STEP = 2'h1;
  localparam logic [LANES-1:0] LANES_NONE = 2'h0;
  localparam logic [LANES-1:0] LANES_ALL = 2'h3;

  typedef enum logic [1:0] {
    FBSS_IDLE,
    FBSS_READ,
    FBSS_WRITE
  } fbss_cycle_t;
endpackage : fbss_pkg

//--- rtl/fbss_top.sv
`timescale 1ns/100ps
// How it works
// - one million words of eighteen bits
// - processor strobe low, with all chip enables active and no sleep, starts a read
// - processor strobe start loads the external address
// - processor strobe needs all chip enables active
// - read data flows through without output register
// - step ignored on processor start, later steps
// - order pin high interleaved, low linear
// - global write writes all eighteen bits
// - byte gate low writes selected lanes only
// - lane writes ignored on processor start edge
// - lane write sampled low turns outputs off
// - lane write low latches bus data
// - write burst steps when write and step low
// - controller start needs processor strobe high
// - controller start samples writes for direction
// - three chip enables must all be active
// - lane a and b written independently
// - data pins driven only selected read, enabled
// - sleep ignores inputs, floats outputs, keeps data
module fbss_top (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic [fbss_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [fbss_pkg::DATA_W-1:0] I_DQ,
  output logic [fbss_pkg::DATA_W-1:0] O_DQ,
  output logic O_DQ_OE,
  input wire logic I_PROC_ADDR_STROBE_N,
  input wire logic I_CTRL_ADDR_STROBE_N,
  input wire logic I_BURST_STEP_N,
  input wire logic I_ALL_LANES_WRITE_N,
  input wire logic I_LANE_WRITE_GATE_N,
  input wire logic [fbss_pkg::LANES-1:0] I_LANE_WRITE_N,
  input wire logic I_MASTER_SELECT_N,
  input wire logic I_SELECT_HI,
  input wire logic I_SELECT_LO_N,
  input wire logic I_OUT_EN_N,
  input wire logic I_BURST_ORDER_SEL,
  input wire logic I_SLEEP_REQ
);
  logic [fbss_pkg::DATA_W-1:0] mem [0:fbss_pkg::DEPTH-1];
  logic [fbss_pkg::SYNC_STAGES-1:0] oe_sync_reg;
  logic [fbss_pkg::SYNC_STAGES-1:0] order_sync_reg;
  logic [fbss_pkg::SYNC_STAGES-1:0] sleep_sync_reg;
  logic out_en_n_reg;
  logic order_sel_reg;
  logic sleep_reg;
  fbss_pkg::fbss_cycle_t state_reg;
  fbss_pkg::fbss_cycle_t state_next;
  logic [fbss_pkg::ADDR_W-1:2] addr_hi_reg;
  logic [1:0] base_reg;
  logic [fbss_pkg::BURST_W-1:0] cnt_reg;
  logic [1:0] offset;
  logic [fbss_pkg::ADDR_W-1:0] cur_addr;
  logic [fbss_pkg::DATA_W-1:0] din_reg;
  logic [fbss_pkg::LANES-1:0] lane_reg;
  logic chip_sel;
  logic proc_seen;
  logic proc_start;
  logic ctrl_seen;
  logic ctrl_start;
  logic deselect;
  logic cont;
  logic step;
  logic wr_cmd;
  logic [fbss_pkg::LANES-1:0] lanes;
  logic write_now;
  logic [fbss_pkg::ADDR_W-1:0] write_addr;

  // three-flop filters on the asynchronous pins
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      oe_sync_reg <= {fbss_pkg::SYNC_STAGES{fbss_pkg::OUT_EN_N_RST}};
      order_sync_reg <= {fbss_pkg::SYNC_STAGES{fbss_pkg::ORDER_SEL_RST}};
      sleep_sync_reg <= {fbss_pkg::SYNC_STAGES{fbss_pkg::SLEEP_RST}};
    end else begin
      oe_sync_reg <= {oe_sync_reg[1:0], I_OUT_EN_N};
      order_sync_reg <= {order_sync_reg[1:0], I_BURST_ORDER_SEL};
      sleep_sync_reg <= {sleep_sync_reg[1:0], I_SLEEP_REQ};
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      out_en_n_reg <= fbss_pkg::OUT_EN_N_RST;
      order_sel_reg <= fbss_pkg::ORDER_SEL_RST;
      sleep_reg <= fbss_pkg::SLEEP_RST;
    end else begin
      if (oe_sync_reg[1] == oe_sync_reg[2]) begin
        out_en_n_reg <= oe_sync_reg[2];
      end
      if (order_sync_reg[1] == order_sync_reg[2]) begin
        order_sel_reg <= order_sync_reg[2];
      end
      if (sleep_sync_reg[1] == sleep_sync_reg[2]) begin
        sleep_reg <= sleep_sync_reg[2];
      end
    end
  end

  // start and continuation decode on the sampling edge
  always_comb begin
    chip_sel = !I_MASTER_SELECT_N && I_SELECT_HI && !I_SELECT_LO_N;
    proc_seen = !I_PROC_ADDR_STROBE_N && !I_MASTER_SELECT_N;
    proc_start = proc_seen && chip_sel && !sleep_reg;
    ctrl_seen = !I_CTRL_ADDR_STROBE_N && !proc_seen;
    ctrl_start = ctrl_seen && chip_sel && !sleep_reg;
    deselect = (proc_seen || ctrl_seen) && !chip_sel && !sleep_reg;
    cont = !proc_seen && !ctrl_seen && !sleep_reg && (state_reg != fbss_pkg::FBSS_IDLE);
    step = cont && !I_BURST_STEP_N;
    if (!I_ALL_LANES_WRITE_N) begin
      lanes = fbss_pkg::LANES_ALL;
    end else if (!I_LANE_WRITE_GATE_N) begin
      lanes = ~I_LANE_WRITE_N;
    end else begin
      lanes = fbss_pkg::LANES_NONE;
    end
    wr_cmd = |lanes;
    write_now = wr_cmd && (ctrl_start || cont);
    write_addr = ctrl_start ? I_ADDR : cur_addr;
  end

  always_comb begin
    state_next = state_reg;
    if (proc_start) begin
      state_next = fbss_pkg::FBSS_READ;
    end else if (ctrl_start || cont) begin
      state_next = wr_cmd ? fbss_pkg::FBSS_WRITE : fbss_pkg::FBSS_READ;
    end else if (deselect) begin
      state_next = fbss_pkg::FBSS_IDLE;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_reg <= fbss_pkg::FBSS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // address register and two-bit burst counter
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      addr_hi_reg <= '0;
      base_reg <= 2'h0;
      cnt_reg <= fbss_pkg::BURST_CNT_RST;
    end else if (proc_start || ctrl_start) begin
      addr_hi_reg <= I_ADDR[fbss_pkg::ADDR_W-1:2];
      base_reg <= I_ADDR[1:0];
      cnt_reg <= fbss_pkg::BURST_CNT_RST;
    end else if (step) begin
      cnt_reg <= cnt_reg + fbss_pkg::BURST_CNT_STEP;
    end
  end

  fbss_burst_seq u_seq (
    .i_base(base_reg),
    .i_count(cnt_reg),
    .i_linear(!order_sel_reg),
    .o_offset(offset)
  );

  assign cur_addr = {addr_hi_reg, offset};

  // data input register and lane record
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      din_reg <= '0;
      lane_reg <= fbss_pkg::LANES_NONE;
    end else if (write_now) begin
      din_reg <= I_DQ;
      lane_reg <= lanes;
    end
  end

  // array has no reset so contents survive sleep
  always_ff @(posedge I_CLK) begin
    if (write_now) begin
      for (int l = 0; l < fbss_pkg::LANES; l++) begin
        if (lanes[l]) begin
          mem[write_addr][l*fbss_pkg::LANE_W +: fbss_pkg::LANE_W] <=
            I_DQ[l*fbss_pkg::LANE_W +: fbss_pkg::LANE_W];
        end
      end
    end
  end

  // flow-through: the array word at the registered address, no output stage
  assign O_DQ = mem[cur_addr];
  assign O_DQ_OE = !out_en_n_reg && !sleep_reg &&
    (state_reg == fbss_pkg::FBSS_READ);

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_ARST_N);

  sequence s_proc_start;
    !I_PROC_ADDR_STROBE_N && !I_MASTER_SELECT_N && I_SELECT_HI && !I_SELECT_LO_N &&
      !sleep_reg;
  endsequence

  sequence s_ctrl_write;
    !I_CTRL_ADDR_STROBE_N && I_PROC_ADDR_STROBE_N && chip_sel && !sleep_reg &&
      !I_ALL_LANES_WRITE_N;
  endsequence

  sequence s_idle_hold;
    cont && I_BURST_STEP_N;
  endsequence

  a_proc_read_start: assert property (s_proc_start |=>
    state_reg == fbss_pkg::FBSS_READ && cur_addr[fbss_pkg::ADDR_W-1:2] ==
      $past(I_ADDR[fbss_pkg::ADDR_W-1:2]))
    else $error("processor strobe did not start a read at the new address");

  a_chip_gate: assert property (
    (!I_PROC_ADDR_STROBE_N && !I_MASTER_SELECT_N && !chip_sel && !sleep_reg) |=>
      state_reg == fbss_pkg::FBSS_IDLE)
    else $error("processor strobe acted while deselected");

  a_step_ignored: assert property (s_proc_start ##1 1 |-> cnt_reg == 2'h0)
    else $error("burst counter moved on the processor start edge");

  a_write_step: assert property (
    (cont && wr_cmd && !I_BURST_STEP_N) |=> cnt_reg == 2'($past(cnt_reg) + 2'h1))
    else $error("write burst did not step");

  a_addr_hold: assert property (
    s_idle_hold |=> $stable({addr_hi_reg, base_reg, cnt_reg}))
    else $error("address moved without a step");

  a_upper_fixed: assert property (cont |=> $stable(addr_hi_reg))
    else $error("upper address bits changed inside a burst");

  a_ctrl_write: assert property (s_ctrl_write |=>
    state_reg == fbss_pkg::FBSS_WRITE && lane_reg == fbss_pkg::LANES_ALL &&
      din_reg == $past(I_DQ))
    else $error("controller write did not capture all lanes");

  a_lane_select: assert property (
    (write_now && I_ALL_LANES_WRITE_N) |=> lane_reg == ~$past(I_LANE_WRITE_N))
    else $error("byte lanes written do not follow lane inputs");

  a_write_quiet: assert property ((cont && wr_cmd) |=> !O_DQ_OE)
    else $error("outputs driven after a lane write");

  a_sleep_float: assert property (
    sleep_reg |-> !O_DQ_OE ##1 (!sleep_reg || !O_DQ_OE))
    else $error("outputs driven during sleep");

  a_burst_order: assert property (
    state_reg != fbss_pkg::FBSS_IDLE |-> cur_addr[1:0] ==
      (order_sel_reg ? (base_reg ^ cnt_reg) : 2'(base_reg + cnt_reg)))
    else $error("burst order does not match order pin");

  a_ctrl_blocked: assert property (
    (!I_CTRL_ADDR_STROBE_N && !I_PROC_ADDR_STROBE_N && !I_MASTER_SELECT_N && chip_sel &&
      !sleep_reg) |=> state_reg == fbss_pkg::FBSS_READ && lane_reg == $past(lane_reg))
    else $error("controller strobe acted while processor strobe was low");

  a_lane_latch: assert property (write_now |=> din_reg == $past(I_DQ))
    else $error("bus data not latched on a lane write");

  a_global_lanes: assert property (
    (write_now && !I_ALL_LANES_WRITE_N) |=> lane_reg == fbss_pkg::LANES_ALL)
    else $error("global write did not cover all lanes");

  a_no_lane_read: assert property (
    (cont && I_ALL_LANES_WRITE_N && I_LANE_WRITE_N == fbss_pkg::LANES_ALL) |=>
      state_reg == fbss_pkg::FBSS_READ)
    else $error("continue with no lane selected was not a read");

  a_proc_no_latch: assert property (s_proc_start |=> $stable(din_reg))
    else $error("data latched on a processor start edge");

  a_linear_step: assert property (
    (step && !order_sel_reg) ##1 !order_sel_reg |->
      cur_addr[1:0] == 2'($past(cur_addr[1:0]) + 2'h1))
    else $error("linear burst did not count up by one");

  a_interleave_step: assert property (
    (step && order_sel_reg && cnt_reg == 2'h0) ##1 order_sel_reg |->
      cur_addr == ($past(cur_addr) ^ 20'h1))
    else $error("interleaved burst did not flip the lowest bit first");

  a_ctrl_load: assert property (
    (!I_CTRL_ADDR_STROBE_N && I_PROC_ADDR_STROBE_N && chip_sel && !sleep_reg) |=>
      cur_addr[fbss_pkg::ADDR_W-1:2] == $past(I_ADDR[fbss_pkg::ADDR_W-1:2]))
    else $error("controller strobe did not load the address");

  a_deselect: assert property (
    (!I_CTRL_ADDR_STROBE_N && !chip_sel && !sleep_reg) |=>
      state_reg == fbss_pkg::FBSS_IDLE && !O_DQ_OE)
    else $error("strobe with an inactive enable did not deselect");

  a_sleep_hold: assert property (
    sleep_reg |-> !write_now ##1 ($stable(state_reg) && $stable(cnt_reg)))
    else $error("inputs acted during sleep");
endmodule : fbss_top
